// ==== pkg/gdfm_map.vh ====
// register map, field positions and timing figures of the fault manager
`ifndef GDFM_MAP_VH
`define GDFM_MAP_VH

`define CLK_PERIOD_NS 20

`define ADDR_W 12
`define CTRL_ADDR 12'h000
`define FLAG_ADDR 12'h004
`define LIVE_ADDR 12'h008

`define CTRL_MASK_MLOW 0
`define CTRL_MASK_MHIGH 1
`define CTRL_MASK_PLOW 2
`define CTRL_RESP_LO 3
`define CTRL_RESP_HI 4
`define CTRL_SHUTOFF 5
`define CTRL_TRIP_LO 8
`define CTRL_TRIP_HI 11
`define CTRL_DEG_LO 12
`define CTRL_DEG_HI 13
`define CTRL_CLEAR 16
`define CTRL_RESET 32'h0000_0000
`define CTRL_WMASK 32'h0000_3F3F

`define FLAG_SUMMARY 0
`define FLAG_MLOW 1
`define FLAG_MHIGH 2
`define FLAG_PLOW 3
`define FLAG_OCP 4
`define FLAG_SW_LO 8
`define FLAG_SW_HI 13

`define LIVE_LOGIC_LOW 0
`define LIVE_MOTOR_LOW 1
`define LIVE_MOTOR_HIGH 2
`define LIVE_PUMP_LOW 3
`define LIVE_RAIL_HIGH 4
`define LIVE_OCP_NOW 5
`define LIVE_OCP_LOCK 6
`define LIVE_MHIGH_LOCK 7
`define LIVE_PLOW_LOCK 8
`define LIVE_PIN 9
`define LIVE_RAILS_OK 10

`define OCP_LATCH 2'b00
`define OCP_RETRY 2'b01
`define OCP_REPORT 2'b10
`define OCP_OFF 2'b11

`define DEG0_NS 1000
`define DEG1_NS 2000
`define DEG2_NS 4000
`define DEG3_NS 8000
`define RETRY_NS 4000000

`define CNT_W 16
`define RETRY_W 24
`define SWITCHES 6

`endif

// ==== logic/gate_driver_fault_manager.v ====
// fault supervisor for a three-phase gate driver with an apb register port
//
// Contract
// - any present fault condition pulls the fault indicator low
// - indicator releases only when all faults gone and rails started
// - only overcurrent stays latched low; other faults release by themselves
// - enable toggle or clear command releases latch, only if fault gone
// - latched flags reset on enable low-pulse rising edge or clear command
// - logic supply low: shutdown, gates blocked, only regulators 1 and 3 on
// - unmasked motor low: gates off, regs 1/3 on, others off, flags latch
// - motor low recovery restarts all automatically; flags wait for clear
// - masked supply fault: no action, indicator low while present, flags held
// - unmasked motor high: gates off, only regs 1/3, indicator low, flags
// - motor high recovery restarts regs; gates and flags wait for clear
// - unmasked pump low: gates off, reg 1 off, others run, flags latch
// - pump low recovery releases indicator; gates and flags wait for clear
// - overcurrent when enabled switch drop outlasts selected deglitch time
// - latch mode: gates off or pulled low per style, flags latch
// - latch mode resumes and clears only on clear command or enable pulse
// - retry mode: resumes after retry interval; flags held until retry
// - pump and buck leave high impedance after drive rail high recovers
// - report mode: gates stay active, indicator low and flags latch
// - off mode: overcurrent takes no action and reports nothing; the live register still shows the deglitched drop
`timescale 1ns/1ps
`include "gdfm_map.vh"

module gate_driver_fault_manager #(
   parameter SWITCHES = `SWITCHES,
   parameter [`RETRY_W-1:0] RETRY_CYCLES =
      (`RETRY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
   input wire i_clk_sys,
   input wire i_resetn,
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [`ADDR_W-1:0] i_paddr,
   input wire [31:0] i_pwdata,
   output wire o_pready,
   output reg [31:0] o_prdata,
   output wire o_pslverr,
   input wire i_enable,
   input wire i_rails_ready,
   input wire i_logic_supply_low,
   input wire i_motor_supply_low,
   input wire i_motor_supply_high,
   input wire i_pump_voltage_low,
   input wire i_drive_rail_high,
   input wire [SWITCHES-1:0] i_switch_on,
   input wire [SWITCHES-1:0] i_switch_overdrop,
   input wire i_fault_indicator_n_in,
   output wire o_fault_indicator_n_out,
   output reg o_fault_indicator_n_oe,
   output reg [3:0] o_drain_trip_level,
   output reg o_shutdown_mode,
   output reg o_gate_block,
   output reg o_gate_force_low,
   output reg o_reg1_en,
   output reg o_reg2_en,
   output reg o_reg3_en,
   output reg o_buck_en,
   output reg o_pump_en,
   output reg o_pump_buck_hiz
);

   // nanoseconds to whole clock cycles, rounded up
   function [31:0] ns_to_cycles;
      input [31:0] ns;
      begin
         ns_to_cycles = (ns + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
      end
   endfunction

   function [`CNT_W-1:0] deg_limit;
      input [1:0] sel;
      reg [31:0] cycles;
      begin
         case (sel)
            2'h0: cycles = ns_to_cycles(`DEG0_NS);
            2'h1: cycles = ns_to_cycles(`DEG1_NS);
            2'h2: cycles = ns_to_cycles(`DEG2_NS);
            default: cycles = ns_to_cycles(`DEG3_NS);
         endcase
         deg_limit = cycles[`CNT_W-1:0];
      end
   endfunction

   // only a switch that is driven on can be blamed for a drop
   function switch_over;
      input on;
      input over;
      begin
         switch_over = on & over;
      end
   endfunction

   // set wins over clear
   function flag_next;
      input cur;
      input set;
      input clr;
      begin
         flag_next = set | (cur & ~clr);
      end
   endfunction

   reg [31:0] ctrl_ff;
   reg clear_cmd_ff;
   reg enable_prev_ff;

   // latched status flags
   reg summary_ff;
   reg mlow_flag_ff;
   reg mhigh_flag_ff;
   reg plow_flag_ff;
   reg ocp_flag_ff;
   reg [SWITCHES-1:0] sw_flag_ff;

   // locks held until cleared after recovery; in retry mode the overcurrent lock also ends with the retry interval
   reg mhigh_lock_ff;
   reg plow_lock_ff;
   reg ocp_lock_ff;
   reg [`RETRY_W-1:0] retry_cnt_ff;
   reg [`CNT_W-1:0] deg_cnt_ff [0:SWITCHES-1];

   // combinational terms and next values
   reg [SWITCHES-1:0] sw_trip;
   reg nxt_summary;
   reg nxt_mlow_flag;
   reg nxt_mhigh_flag;
   reg nxt_plow_flag;
   reg nxt_ocp_flag;
   reg [SWITCHES-1:0] nxt_sw_flag;
   reg nxt_mhigh_lock;
   reg nxt_plow_lock;
   reg nxt_ocp_lock;
   reg [`RETRY_W-1:0] nxt_retry_cnt;
   reg [31:0] nxt_prdata;
   integer i;
   integer j;

   wire apb_access = i_psel & i_penable;
   wire wr_access = apb_access & i_pwrite;
   wire addr_ok = (i_paddr == `CTRL_ADDR) | (i_paddr == `FLAG_ADDR) |
                  (i_paddr == `LIVE_ADDR);
   wire ctrl_wr = wr_access & (i_paddr == `CTRL_ADDR);

   wire mask_mlow = ctrl_ff[`CTRL_MASK_MLOW];
   wire mask_mhigh = ctrl_ff[`CTRL_MASK_MHIGH];
   wire mask_plow = ctrl_ff[`CTRL_MASK_PLOW];
   wire [1:0] resp = ctrl_ff[`CTRL_RESP_HI:`CTRL_RESP_LO];
   wire shutoff_style = ctrl_ff[`CTRL_SHUTOFF];
   wire [1:0] deg_sel = ctrl_ff[`CTRL_DEG_HI:`CTRL_DEG_LO];
   wire [`CNT_W-1:0] deg_max = deg_limit(deg_sel);

   // end of an enable low pulse, or the clear command
   wire clear_evt = (i_enable & ~enable_prev_ff) | clear_cmd_ff;

   wire mlow_act = i_motor_supply_low & ~mask_mlow;
   wire mhigh_act = i_motor_supply_high & ~mask_mhigh;
   wire plow_act = i_pump_voltage_low & ~mask_plow;
   wire ocp_now = |sw_trip;
   wire ocp_counted = ocp_now & (resp != `OCP_OFF);
   wire ocp_stops = (resp == `OCP_LATCH) | (resp == `OCP_RETRY);
   wire retry_done = ocp_lock_ff & (resp == `OCP_RETRY) &
                     (retry_cnt_ff == RETRY_CYCLES);

   // overcurrent clears only once the drop is gone
   wire ocp_clear = clear_evt & ~ocp_now;
   // supply faults that take the main regulator chain down
   wire chain_off = i_logic_supply_low | mlow_act | mhigh_act;

   // overcurrent pull: lock, a fresh trip outside retry, a report-mode flag
   wire ocp_pull = ocp_lock_ff | (ocp_counted & (resp != `OCP_RETRY)) |
                   (ocp_flag_ff & (resp == `OCP_REPORT));

   assign o_pready = 1'b1;
   assign o_pslverr = apb_access & ~addr_ok;
   assign o_fault_indicator_n_out = 1'b0;

   // deglitch per switch: drop must persist on an enabled switch
   always @* begin
      for (i = 0; i < SWITCHES; i = i + 1) begin
         sw_trip[i] = switch_over(i_switch_on[i], i_switch_overdrop[i]) &
                      (deg_cnt_ff[i] >= deg_max);
      end
   end

   always @(posedge i_clk_sys) begin
      for (j = 0; j < SWITCHES; j = j + 1) begin
         if (!i_resetn) begin
            deg_cnt_ff[j] <= {`CNT_W{1'b0}};
         end else if (!switch_over(i_switch_on[j], i_switch_overdrop[j])) begin
            deg_cnt_ff[j] <= {`CNT_W{1'b0}};
         end else if (deg_cnt_ff[j] < deg_max) begin
            deg_cnt_ff[j] <= deg_cnt_ff[j] + 1'b1;
         end
      end
   end

   always @* begin
      nxt_mlow_flag = flag_next(mlow_flag_ff, i_motor_supply_low, clear_evt);
      nxt_mhigh_flag = flag_next(mhigh_flag_ff, i_motor_supply_high, clear_evt);
      nxt_plow_flag = flag_next(plow_flag_ff, i_pump_voltage_low, clear_evt);
      // motor high and pump low hold the gates until cleared after recovery
      nxt_mhigh_lock = flag_next(mhigh_lock_ff, mhigh_act,
                                 clear_evt & ~i_motor_supply_high);
      nxt_plow_lock = flag_next(plow_lock_ff, plow_act,
                                clear_evt & ~i_pump_voltage_low);
      nxt_ocp_lock = flag_next(ocp_lock_ff, ocp_counted & ocp_stops,
                               ocp_clear | retry_done);
      nxt_ocp_flag = ocp_flag_ff;
      nxt_sw_flag = sw_flag_ff;
      if (ocp_counted) begin
         nxt_ocp_flag = 1'b1;
         nxt_sw_flag = sw_flag_ff | sw_trip;
      end else if (retry_done | ocp_clear) begin
         nxt_ocp_flag = 1'b0;
         nxt_sw_flag = {SWITCHES{1'b0}};
      end
      // retry interval runs only while the retry lock holds
      if (!ocp_lock_ff || resp != `OCP_RETRY || retry_done) begin
         nxt_retry_cnt = {`RETRY_W{1'b0}};
      end else begin
         nxt_retry_cnt = retry_cnt_ff + 1'b1;
      end
      nxt_summary = nxt_mlow_flag | nxt_mhigh_flag | nxt_plow_flag |
                    nxt_ocp_flag;
   end

   always @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         ctrl_ff <= `CTRL_RESET;
         clear_cmd_ff <= 1'b0;
         enable_prev_ff <= 1'b0;
         summary_ff <= 1'b0;
         mlow_flag_ff <= 1'b0;
         mhigh_flag_ff <= 1'b0;
         plow_flag_ff <= 1'b0;
         ocp_flag_ff <= 1'b0;
         sw_flag_ff <= {SWITCHES{1'b0}};
         mhigh_lock_ff <= 1'b0;
         plow_lock_ff <= 1'b0;
         ocp_lock_ff <= 1'b0;
         retry_cnt_ff <= {`RETRY_W{1'b0}};
      end else begin
         if (ctrl_wr) begin
            ctrl_ff <= i_pwdata & `CTRL_WMASK;
         end
         clear_cmd_ff <= ctrl_wr & i_pwdata[`CTRL_CLEAR];
         enable_prev_ff <= i_enable;
         summary_ff <= nxt_summary;
         mlow_flag_ff <= nxt_mlow_flag;
         mhigh_flag_ff <= nxt_mhigh_flag;
         plow_flag_ff <= nxt_plow_flag;
         ocp_flag_ff <= nxt_ocp_flag;
         sw_flag_ff <= nxt_sw_flag;
         mhigh_lock_ff <= nxt_mhigh_lock;
         plow_lock_ff <= nxt_plow_lock;
         ocp_lock_ff <= nxt_ocp_lock;
         retry_cnt_ff <= nxt_retry_cnt;
      end
   end

   // driver side outputs, registered
   always @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         o_fault_indicator_n_oe <= 1'b1;
         o_drain_trip_level <= 4'h0;
         o_shutdown_mode <= 1'b0;
         o_gate_block <= 1'b1;
         o_gate_force_low <= 1'b0;
         o_reg1_en <= 1'b1;
         o_reg2_en <= 1'b0;
         o_reg3_en <= 1'b1;
         o_buck_en <= 1'b0;
         o_pump_en <= 1'b0;
         o_pump_buck_hiz <= 1'b0;
      end else begin
         o_fault_indicator_n_oe <= i_logic_supply_low | i_motor_supply_low |
                                   i_motor_supply_high | i_pump_voltage_low |
                                   i_drive_rail_high | ~i_rails_ready |
                                   ocp_pull;
         o_drain_trip_level <= ctrl_ff[`CTRL_TRIP_HI:`CTRL_TRIP_LO];
         o_shutdown_mode <= i_logic_supply_low;
         o_gate_block <= i_logic_supply_low | mlow_act | mhigh_act |
                         mhigh_lock_ff | plow_act | plow_lock_ff |
                         (ocp_lock_ff & ~shutoff_style);
         o_gate_force_low <= ocp_lock_ff & shutoff_style &
                             ~i_logic_supply_low;
         o_reg1_en <= chain_off | ~plow_act;
         o_reg3_en <= 1'b1;
         o_reg2_en <= ~chain_off;
         o_buck_en <= ~chain_off;
         o_pump_en <= ~chain_off;
         o_pump_buck_hiz <= i_drive_rail_high;
      end
   end

   always @* begin
      nxt_prdata = 32'h0000_0000;
      case (i_paddr)
         `CTRL_ADDR: begin
            nxt_prdata = ctrl_ff;
         end
         `FLAG_ADDR: begin
            nxt_prdata[`FLAG_SUMMARY] = summary_ff;
            nxt_prdata[`FLAG_MLOW] = mlow_flag_ff;
            nxt_prdata[`FLAG_MHIGH] = mhigh_flag_ff;
            nxt_prdata[`FLAG_PLOW] = plow_flag_ff;
            nxt_prdata[`FLAG_OCP] = ocp_flag_ff;
            nxt_prdata[`FLAG_SW_HI:`FLAG_SW_LO] = sw_flag_ff;
         end
         `LIVE_ADDR: begin
            // raw conditions and locks, for diagnosis
            nxt_prdata[`LIVE_LOGIC_LOW] = i_logic_supply_low;
            nxt_prdata[`LIVE_MOTOR_LOW] = i_motor_supply_low;
            nxt_prdata[`LIVE_MOTOR_HIGH] = i_motor_supply_high;
            nxt_prdata[`LIVE_PUMP_LOW] = i_pump_voltage_low;
            nxt_prdata[`LIVE_RAIL_HIGH] = i_drive_rail_high;
            nxt_prdata[`LIVE_OCP_NOW] = ocp_now;
            nxt_prdata[`LIVE_OCP_LOCK] = ocp_lock_ff;
            nxt_prdata[`LIVE_MHIGH_LOCK] = mhigh_lock_ff;
            nxt_prdata[`LIVE_PLOW_LOCK] = plow_lock_ff;
            nxt_prdata[`LIVE_PIN] = i_fault_indicator_n_in;
            nxt_prdata[`LIVE_RAILS_OK] = i_rails_ready;
         end
         default: begin
            nxt_prdata = 32'h0000_0000;
         end
      endcase
   end

   // read data captured in setup so it stands in the access phase
   always @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         o_prdata <= 32'h0000_0000;
      end else if (i_psel & ~i_penable & ~i_pwrite) begin
         o_prdata <= nxt_prdata;
      end
   end

endmodule

// ==== test/fault_checker.sv ====
// concurrent checks on the fault manager ports
`timescale 1ns/1ps
`include "gdfm_map.vh"
module fault_checker (
   input wire i_clk_sys,
   input wire i_resetn,
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [`ADDR_W-1:0] i_paddr,
   input wire [31:0] i_pwdata,
   input wire i_rails_ready,
   input wire i_logic_supply_low,
   input wire i_motor_supply_low,
   input wire i_motor_supply_high,
   input wire i_pump_voltage_low,
   input wire i_drive_rail_high,
   input wire o_fault_indicator_n_oe,
   input wire o_shutdown_mode,
   input wire o_gate_block,
   input wire o_gate_force_low,
   input wire o_reg1_en,
   input wire o_reg2_en,
   input wire o_buck_en,
   input wire o_pump_en,
   input wire o_pump_buck_hiz
);
   reg [31:0] ctrl_ff;
   reg [1:0] up_ff;
   wire up = up_ff[1];
   wire oe = o_fault_indicator_n_oe;
   wire lo = i_logic_supply_low;
   wire ml = i_motor_supply_low;
   wire mh = i_motor_supply_high;
   wire raw = lo | ml | mh | i_pump_voltage_low | i_drive_rail_high;
   // mirror of control writes
   always @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         ctrl_ff <= 32'h0000_0000;
         up_ff <= 2'h0;
      end else begin
         if (!up_ff[1]) begin
            up_ff <= up_ff + 2'h1;
         end
         if (i_psel && i_penable && i_pwrite && i_paddr == `CTRL_ADDR) begin
            ctrl_ff <= i_pwdata & `CTRL_WMASK;
         end
      end
   end
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_resetn);
   a_fault_pulls_low: assert property (up && raw |=> oe)
      else $error("indicator not low on fault");
   a_rails_hold_low: assert property (up && !i_rails_ready |=> oe)
      else $error("indicator released before rails ready");
   a_shutdown_state: assert property (up && lo |=> o_shutdown_mode && o_gate_block
      && o_reg1_en && !o_reg2_en && !o_buck_en && !o_pump_en)
      else $error("logic supply low state wrong");
   a_motor_low_off: assert property (up && ml && !ctrl_ff[0] |=> o_gate_block && oe
      && o_reg1_en && !o_reg2_en && !o_buck_en && !o_pump_en)
      else $error("motor low action wrong");
   a_masked_keeps_mode: assert property (up && ml && ctrl_ff[0] && !lo && !mh
      |=> o_reg2_en && oe)
      else $error("masked motor low changed mode");
   a_motor_high_off: assert property (up && mh && !ctrl_ff[1] |=> o_gate_block
      && !o_reg2_en && oe)
      else $error("motor high action wrong");
   a_pump_low_mix: assert property (up && i_pump_voltage_low && !ctrl_ff[2] && !lo
      && !ml && !mh |=> o_gate_block && !o_reg1_en && o_reg2_en && o_pump_en && o_buck_en)
      else $error("pump low action wrong");
   a_force_low_cause: assert property ($rose(o_gate_force_low) |-> ctrl_ff[5]
      && !ctrl_ff[4])
      else $error("force low without shutoff style");
   a_hiz_release: assert property (up && $fell(i_drive_rail_high) |=> !o_pump_buck_hiz)
      else $error("pump and buck stay high impedance");
endmodule

bind gate_driver_fault_manager fault_checker u_chk (
   .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_psel(i_psel), .i_penable(i_penable),
   .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
   .i_rails_ready(i_rails_ready), .i_logic_supply_low(i_logic_supply_low),
   .i_motor_supply_low(i_motor_supply_low), .i_motor_supply_high(i_motor_supply_high),
   .i_pump_voltage_low(i_pump_voltage_low), .i_drive_rail_high(i_drive_rail_high),
   .o_fault_indicator_n_oe(o_fault_indicator_n_oe), .o_shutdown_mode(o_shutdown_mode),
   .o_gate_block(o_gate_block), .o_gate_force_low(o_gate_force_low),
   .o_reg1_en(o_reg1_en), .o_reg2_en(o_reg2_en), .o_buck_en(o_buck_en),
   .o_pump_en(o_pump_en), .o_pump_buck_hiz(o_pump_buck_hiz));

// ==== test/host_model.sv ====
// host side: enable pin and pulled-up fault line
`timescale 1ns/1ps
module host_model (
   input wire i_clk_sys,
   input wire i_pin_drive,
   input wire i_pin_oe,
   output reg o_enable,
   output wire o_fault_line
);
   assign o_fault_line = i_pin_oe ? i_pin_drive : 1'b1;
   initial o_enable = 1'b1;
   task pulse_enable;
      begin
         @(posedge i_clk_sys);
         o_enable <= 1'b0;
         repeat (3) @(posedge i_clk_sys);
         o_enable <= 1'b1;
      end
   endtask
endmodule

// ==== test/testbench.sv ====
// self-checking bench for the fault manager
`timescale 1ns/1ps
`include "gdfm_map.vh"
module testbench;
   reg clk = 1'b0;
   reg resetn = 1'b0;
   reg psel = 1'b0;
   reg penable = 1'b0;
   reg pwrite = 1'b0;
   reg [11:0] paddr = 12'h000;
   reg [31:0] pwdata = 32'h0000_0000;
   reg rails = 1'b1;
   reg [4:0] cond = 5'h00;
   reg [5:0] sw_over = 6'h00;
   reg [5:0] sw_on = 6'h3F;
   reg [31:0] rd;
   reg err;
   wire pready, pslverr, oe, drv, en, line, shut, gblk, flow, r1, r2, bk, pmp, hiz;
   wire [31:0] prdata;
   wire [3:0] trip;
   wire r3;
   integer fail_count = 0;
   integer comparisons = 0;
   integer cyc = 0;
   integer m;
   always #10 clk = ~clk;
   gate_driver_fault_manager #(.RETRY_CYCLES(40)) u_dut (.i_clk_sys(clk), .i_resetn(resetn),
      .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
      .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
      .i_enable(en), .i_rails_ready(rails), .i_logic_supply_low(cond[0]),
      .i_motor_supply_low(cond[1]), .i_motor_supply_high(cond[2]),
      .i_pump_voltage_low(cond[3]), .i_drive_rail_high(cond[4]), .i_switch_on(sw_on),
      .i_switch_overdrop(sw_over), .i_fault_indicator_n_in(line),
      .o_fault_indicator_n_out(drv), .o_fault_indicator_n_oe(oe), .o_drain_trip_level(trip),
      .o_shutdown_mode(shut), .o_gate_block(gblk), .o_gate_force_low(flow), .o_reg1_en(r1),
      .o_reg2_en(r2), .o_reg3_en(r3), .o_buck_en(bk), .o_pump_en(pmp), .o_pump_buck_hiz(hiz));
   host_model u_host (.i_clk_sys(clk), .i_pin_drive(drv), .i_pin_oe(oe), .o_enable(en),
      .o_fault_line(line));
   task finish_test;
      begin
         $display("comparisons %0d fail_count %0d", comparisons, fail_count);
         if (fail_count == 0 && comparisons > 0) begin
            $display("TEST PASSED");
         end else begin
            $display("TEST FAILED");
         end
         $finish;
      end
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fail_count = fail_count + 1;
         finish_test;
      end
   end
   task check(input [63:0] name, input [31:0] seen, input [31:0] exp);
      begin
         comparisons = comparisons + 1;
         if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("unexpected %0s expected %h seen %h", name, exp, seen);
         end
      end
   endtask
   task apb(input wr, input [11:0] a, input [31:0] d);
      begin
         @(posedge clk);
         psel <= 1'b1;
         pwrite <= wr;
         paddr <= a;
         pwdata <= d;
         @(posedge clk);
         penable <= 1'b1;
         @(posedge clk);
         while (pready !== 1'b1) @(posedge clk);
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task settle(input integer n);
      begin
         repeat (n) @(posedge clk);
         #1;
      end
   endtask
   task drive(input [4:0] c, input r);
      begin
         @(posedge clk);
         cond <= c;
         rails <= r;
         settle(4);
      end
   endtask
   initial begin
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      settle(5);
      check("pin", line, 32'h1);
      apb(1'b0, `CTRL_ADDR, 32'h0);
      check("ctrl", rd, `CTRL_RESET);
      apb(1'b1, `CTRL_ADDR, 32'hFFFF_FFFF);
      apb(1'b0, `CTRL_ADDR, 32'h0);
      check("ctrl", rd, `CTRL_WMASK);
      check("trip", trip, 32'hF);
      apb(1'b0, 12'h00C, 32'h0);
      check("slverr", err, 32'h1);
      check("rdata", rd, 32'h0);
      drive(5'h00, 1'b0);
      check("pin", line, 32'h0);
      drive(5'h02, 1'b1);
      check("pin", line, 32'h0);
      check("reg2", r2, 32'h1);
      drive(5'h00, 1'b1);
      check("pin", line, 32'h1);
      apb(1'b0, `FLAG_ADDR, 32'h0);
      check("flag", rd, 32'h3);
      apb(1'b1, `CTRL_ADDR, 32'h0001_0000);
      for (m = 1; m < 4; m = m + 1) begin
         drive(5'h01 << m, 1'b1);
         check("pin", line, 32'h0);
         check("reg1", r1, m != 3);
         check("reg2", {gblk, r2, bk, pmp}, (m == 3) ? 32'hF : 32'h8);
         drive(5'h00, 1'b1);
         check("pin", line, 32'h1);
         check("gate", gblk, m != 1);
         apb(1'b0, `FLAG_ADDR, 32'h0);
         check("flag", rd, 32'h1 | (32'h1 << m));
         if (m == 2) begin
            apb(1'b1, `CTRL_ADDR, 32'h0001_0000);
         end else begin
            u_host.pulse_enable;
         end
         settle(4);
         check("gate", gblk, 32'h0);
         apb(1'b0, `FLAG_ADDR, 32'h0);
         check("flag", rd, 32'h0);
      end
      drive(5'h01, 1'b1);
      check("shut", {shut, r2, r3}, 32'h5);
      drive(5'h10, 1'b1);
      check("hiz", {shut, hiz, line}, 32'h2);
      apb(1'b0, `LIVE_ADDR, 32'h0);
      check("live", rd, 32'h410);
      drive(5'h00, 1'b1);
      check("hiz", {hiz, line}, 32'h1);
      @(posedge clk);
      sw_over <= 6'h04;
      repeat (40) @(posedge clk);
      sw_on <= 6'h3B;
      repeat (40) @(posedge clk);
      sw_over <= 6'h00;
      sw_on <= 6'h3F;
      settle(4);
      check("pin", line, 32'h1);
      apb(1'b1, `CTRL_ADDR, 32'h0000_1000);
      sw_over <= 6'h04;
      repeat (60) @(posedge clk);
      sw_over <= 6'h00;
      settle(4);
      check("pin", line, 32'h1);
      for (m = 0; m < 4; m = m + 1) begin
         apb(1'b1, `CTRL_ADDR, (m << 3) | ((m == 1) ? 32'h20 : 32'h0));
         sw_over <= 6'h04;
         repeat (60) @(posedge clk);
         sw_over <= 6'h00;
         settle(4);
         check("pin", line, m == 3);
         check("gate", {gblk, flow}, (m == 0) ? 32'h2 : (m == 1) ? 32'h1 : 32'h0);
         apb(1'b0, `FLAG_ADDR, 32'h0);
         check("flag", rd, (m == 3) ? 32'h0 : 32'h411);
         if (m == 1) begin
            settle(40);
         end else begin
            u_host.pulse_enable;
            settle(4);
         end
         check("pin", {line, gblk, flow}, 32'h4);
         apb(1'b0, `FLAG_ADDR, 32'h0);
         check("flag", rd, 32'h0);
      end
      finish_test;
   end
endmodule
